// ### tuner_control_register_bank.sv
`timescale 1ns/1ps
// Behaviour
// - Address 0x01 holds divider bits 7..0; divider spans 256 to 32767.
// - Address 0x02 bits 6..0 set the reference divider; host keeps 16..127.
// - Oscillator bits 7..6: 00 all off, else first, second, third oscillator.
// - Oscillator bits 5..3 pick sub-band zero to seven directly.
// - Oscillator bit 2 enables lock detection when set.
// - Oscillator bits 1..0 pick output divide by 4, 8, 16 or 32.
// - Bits 3..2 of 0x04 set pump current 0.5, 1, 1.5 or 2 mA.
// - Bits 1..0 of 0x04 pick filter band; host never writes 11.
// - Bit 3 of 0x05 set turns RF circuitry off.
// - Bit 2 of 0x05 set powers down the IF amplifier.
// - Bits 1..0 of 0x05 pick RF input; host never writes 11.
// - Bits 7..6 of 0x06: 00 mixer runs, 11 mixer off; host avoids others.
// - Bit 4 of 0x06 set turns the overload detector off.
// - Bit 3 of 0x06 set turns the synthesizer off.
// - Address 0x07 drives the eight-bit series capacitor code.
// - Only a 0 to 1 write of 0x08 bit 7 loads the ROM readback.
// - Bits 5..0 of 0x08 drive the parallel capacitor code.
// - Bits 3..0 of 0x09 pick which ROM entry a load fetches.
// - Address 0x00 bits 6..0 hold divider bits 14..8.
// - Read-only 0x0B returns the fetched ROM byte.
// - After a start address, each data byte goes to the next register.
// - Status bit 7 reads 1 after reset, clears once status is read.
module tuner_control_register_bank
    import tuner_regs_pkg::*;
#(
    parameter int ROM_SIZE = ROM_ENTRIES,
    parameter logic [ROM_ENTRIES*8-1:0] ROM_CONTENT = '0
) (
    input wire logic clk, // 100 MHz clock
    input wire logic srst, // Synchronous reset, active high
    input wire link_cmd_t cmd, // Byte events from the serial engine
    input wire logic [2:0] lockIndicator, // Tuning voltage indicator, asynchronous
    output tuner_ctrl_t ctrl, // Fields that steer the analogue blocks
    output logic [7:0] readData, // Byte answering a read request
    output logic readValid // One-cycle pulse with readData
);
    // ********************************************************************
    // Parameter checks
    // ********************************************************************
    // The pointer field is four bits wide, so the table must match it
    if (ROM_SIZE != ROM_ENTRIES) begin : g_bad_rom
        $error("ROM_SIZE must be 16");
    end

    bank_state_t st;
    bank_state_t next_st;
    logic writeTaken;
    logic loadNow;
    logic [7:0] romEntry;

    // ********************************************************************
    // Next state
    // ********************************************************************
    // Data bytes count only inside an open transfer; a stray byte is dropped
    assign writeTaken = cmd.writeValid && !cmd.addrValid && !cmd.stop
        && (st.phase == PH_ADDRESSED);
    // Entry comes from the pointer as stored before this cycle; a pointer byte later in the same burst serves the next load
    assign romEntry = ROM_CONTENT[st.bank[ADDR_ROM_PTR[3:0]][3:0]*8 +: 8];
    // Compare with the stored bit so that rewriting a set bit never reloads
    assign loadNow = writeTaken && (st.pointer == ADDR_PARALLEL) && cmd.data[LOAD_BIT]
        && !st.bank[ADDR_PARALLEL[3:0]][LOAD_BIT];

    always_comb begin
        next_st = st;
        next_st.readValid = 1'b0;
        // Two flops tame the asynchronous indicator; only the second one is read
        next_st.lockSync1 = lockIndicator;
        next_st.lockSync2 = st.lockSync1;
        if (cmd.stop) begin
            next_st.phase = PH_IDLE;
        end else if (cmd.addrValid) begin
            next_st.pointer = cmd.data;
            next_st.phase = PH_ADDRESSED;
        end else if (writeTaken) begin
            // Read-only and unmapped addresses swallow the byte
            if (st.pointer <= ADDR_RESERVED) begin
                next_st.bank[st.pointer[3:0]] = cmd.data;
            end
            if (loadNow) begin
                next_st.romReadbackValue = romEntry;
            end
            next_st.pointer = st.pointer + 8'h01;
        end else if (cmd.readReq) begin
            next_st.readValid = 1'b1;
            if (st.pointer <= ADDR_RESERVED) begin
                next_st.readData = st.bank[st.pointer[3:0]];
            end else if (st.pointer == ADDR_ROM_DATA) begin
                next_st.readData = st.romReadbackValue;
            end else if (st.pointer == ADDR_STATUS) begin
                // Reserved status bits read as zero
                next_st.readData = {st.powerOnFlag, st.lockSync2, 4'h0};
                next_st.powerOnFlag = 1'b0;
            end else begin
                // Unmapped addresses answer zero rather than stalling the link
                next_st.readData = 8'h00;
            end
            next_st.pointer = st.pointer + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st.phase <= PH_IDLE;
            st.pointer <= 8'h00;
            // Fixed defaults only; the host is expected to rewrite every field anyway
            st.bank <= BANK_RESET;
            st.romReadbackValue <= 8'h00;
            st.powerOnFlag <= 1'b1;
            st.lockSync1 <= 3'h0;
            st.lockSync2 <= 3'h0;
            st.readData <= 8'h00;
            st.readValid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ********************************************************************
    // Field outputs
    // ********************************************************************
    // Plain slices with no shadowing: a divider change lands one byte at a time
    assign ctrl.intDivider = {st.bank[ADDR_DIV_HIGH[3:0]][6:0],
        st.bank[ADDR_DIV_LOW[3:0]]};
    assign ctrl.refDivider = st.bank[ADDR_REF_DIV[3:0]][6:0];
    assign ctrl.oscillatorSelect = st.bank[ADDR_OSC[3:0]][7:6];
    assign ctrl.subBandSelect = st.bank[ADDR_OSC[3:0]][5:3];
    assign ctrl.lockDetectEnable = st.bank[ADDR_OSC[3:0]][2];
    assign ctrl.outputDividerRatio = st.bank[ADDR_OSC[3:0]][1:0];
    assign ctrl.overloadDetectorSetting = st.bank[ADDR_DET_PUMP[3:0]][6:4];
    assign ctrl.pumpCurrentSelect = st.bank[ADDR_DET_PUMP[3:0]][3:2];
    assign ctrl.filterBandSelect = st.bank[ADDR_DET_PUMP[3:0]][1:0];
    assign ctrl.rfPowerOff = st.bank[ADDR_INPUT[3:0]][3];
    assign ctrl.ifAmpPowerOff = st.bank[ADDR_INPUT[3:0]][2];
    assign ctrl.rfInputSelect = st.bank[ADDR_INPUT[3:0]][1:0];
    assign ctrl.mixerPowerOff = st.bank[ADDR_POWER[3:0]][7:6];
    assign ctrl.ifSectionPowerOff = st.bank[ADDR_POWER[3:0]][5];
    assign ctrl.detectorPowerOff = st.bank[ADDR_POWER[3:0]][4];
    assign ctrl.synthesizerPowerOff = st.bank[ADDR_POWER[3:0]][3];
    assign ctrl.seriesCapCode = st.bank[ADDR_SERIES[3:0]];
    assign ctrl.parallelCapCode = st.bank[ADDR_PARALLEL[3:0]][5:0];
    assign ctrl.romEntryPointer = st.bank[ADDR_ROM_PTR[3:0]][3:0];
    assign readData = st.readData;
    assign readValid = st.readValid;

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    property p_div_low_write;
        writeTaken && st.pointer == ADDR_DIV_LOW
            |=> ctrl.intDivider[7:0] == $past(cmd.data) && $stable(ctrl.intDivider[14:8]);
    endproperty
    a_div_low_write: assert property (p_div_low_write)
        else $error("divider low byte not stored");

    property p_div_high_write;
        writeTaken && st.pointer == ADDR_DIV_HIGH
            |=> ctrl.intDivider[14:8] == $past(cmd.data[6:0]);
    endproperty
    a_div_high_write: assert property (p_div_high_write)
        else $error("divider high bits not stored");

    property p_osc_fields;
        writeTaken && st.pointer == ADDR_OSC |=> ctrl.oscillatorSelect == $past(cmd.data[7:6])
            && ctrl.subBandSelect == $past(cmd.data[5:3])
            && ctrl.lockDetectEnable == $past(cmd.data[2])
            && ctrl.outputDividerRatio == $past(cmd.data[1:0]);
    endproperty
    a_osc_fields: assert property (p_osc_fields)
        else $error("oscillator fields wrong after write");

    property p_power_fields;
        writeTaken && st.pointer == ADDR_POWER |=> ctrl.mixerPowerOff == $past(cmd.data[7:6])
            && ctrl.ifSectionPowerOff == $past(cmd.data[5])
            && ctrl.detectorPowerOff == $past(cmd.data[4])
            && ctrl.synthesizerPowerOff == $past(cmd.data[3]);
    endproperty
    a_power_fields: assert property (p_power_fields)
        else $error("power-down fields wrong after write");

    property p_burst_increment;
        writeTaken ##1 (writeTaken && !cmd.readReq)
            |=> st.pointer == $past(st.pointer, 2) + 8'h02;
    endproperty
    a_burst_increment: assert property (p_burst_increment)
        else $error("burst pointer did not advance by two");

    property p_idle_ignores_data;
        st.phase == PH_IDLE && cmd.writeValid && !cmd.addrValid && !cmd.stop
            |=> $stable(st.bank) && $stable(st.pointer);
    endproperty
    a_idle_ignores_data: assert property (p_idle_ignores_data)
        else $error("data stored outside a transfer");

    property p_rom_load;
        loadNow |=> st.romReadbackValue
            == ROM_CONTENT[$past(ctrl.romEntryPointer)*8 +: 8];
    endproperty
    a_rom_load: assert property (p_rom_load)
        else $error("ROM entry not fetched on load");

    property p_no_load_without_rise;
        writeTaken && st.pointer == ADDR_PARALLEL && st.bank[ADDR_PARALLEL[3:0]][LOAD_BIT]
            |=> $stable(st.romReadbackValue);
    endproperty
    a_no_load_without_rise: assert property (p_no_load_without_rise)
        else $error("readback loaded without a rising load bit");

    property p_status_read;
        cmd.readReq && !cmd.addrValid && !cmd.stop && !writeTaken && st.pointer == ADDR_STATUS
            |=> readValid && readData[POR_BIT] == $past(st.powerOnFlag) && !st.powerOnFlag;
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read did not report and clear the reset flag");

    property p_readback;
        cmd.readReq && !cmd.addrValid && !cmd.stop && !writeTaken && st.pointer <= ADDR_RESERVED
            |=> readValid && readData == $past(st.bank[st.pointer[3:0]]);
    endproperty
    a_readback: assert property (p_readback)
        else $error("read did not return stored byte");

    // Divider default 4688 sits across the two divider bytes
    property p_reset_values;
        $past(srst) |-> ctrl.intDivider == 15'h1250 && st.powerOnFlag && !readValid;
    endproperty
    a_reset_values: assert property (p_reset_values)
        else $error("register values wrong after reset");

    // ********************************************************************
    // Field write checks
    // ********************************************************************
    property p_ref_div_write;
        writeTaken && st.pointer == ADDR_REF_DIV
            |=> ctrl.refDivider == $past(cmd.data[6:0]);
    endproperty
    a_ref_div_write: assert property (p_ref_div_write)
        else $error("reference divider not stored");

    property p_det_pump_fields;
        writeTaken && st.pointer == ADDR_DET_PUMP
            |=> ctrl.overloadDetectorSetting == $past(cmd.data[6:4])
            && ctrl.pumpCurrentSelect == $past(cmd.data[3:2])
            && ctrl.filterBandSelect == $past(cmd.data[1:0]);
    endproperty
    a_det_pump_fields: assert property (p_det_pump_fields)
        else $error("detector, pump or band field wrong after write");

    property p_input_fields;
        writeTaken && st.pointer == ADDR_INPUT
            |=> ctrl.rfPowerOff == $past(cmd.data[3])
            && ctrl.ifAmpPowerOff == $past(cmd.data[2])
            && ctrl.rfInputSelect == $past(cmd.data[1:0]);
    endproperty
    a_input_fields: assert property (p_input_fields)
        else $error("input control fields wrong after write");

    property p_series_write;
        writeTaken && st.pointer == ADDR_SERIES |=> ctrl.seriesCapCode == $past(cmd.data);
    endproperty
    a_series_write: assert property (p_series_write)
        else $error("series capacitor code not stored");

    property p_parallel_write;
        writeTaken && st.pointer == ADDR_PARALLEL
            |=> ctrl.parallelCapCode == $past(cmd.data[5:0]);
    endproperty
    a_parallel_write: assert property (p_parallel_write)
        else $error("parallel capacitor code not stored");

    property p_pointer_write;
        writeTaken && st.pointer == ADDR_ROM_PTR
            |=> ctrl.romEntryPointer == $past(cmd.data[3:0]);
    endproperty
    a_pointer_write: assert property (p_pointer_write)
        else $error("ROM entry pointer not stored");

    // ********************************************************************
    // Read and framing checks
    // ********************************************************************
    // These lean on the command priority: stop, address, write, then read
    property p_rom_read;
        cmd.readReq && !cmd.addrValid && !cmd.stop && !writeTaken && st.pointer == ADDR_ROM_DATA
            |=> readValid && readData == $past(st.romReadbackValue);
    endproperty
    a_rom_read: assert property (p_rom_read)
        else $error("ROM readback register not returned");

    property p_lock_status;
        cmd.readReq && !cmd.addrValid && !cmd.stop && !writeTaken && st.pointer == ADDR_STATUS
            |=> readData[6:4] == $past(st.lockSync2) && readData[3:0] == 4'h0;
    endproperty
    a_lock_status: assert property (p_lock_status)
        else $error("status lock bits wrong");

    property p_read_only_kept;
        writeTaken && st.pointer > ADDR_RESERVED
            |=> $stable(st.bank) && st.pointer == $past(st.pointer) + 8'h01;
    endproperty
    a_read_only_kept: assert property (p_read_only_kept)
        else $error("write above the bank changed a register");

    property p_read_data_holds;
        !(cmd.readReq && !cmd.addrValid && !cmd.stop && !writeTaken) |=> $stable(readData);
    endproperty
    a_read_data_holds: assert property (p_read_data_holds)
        else $error("read data changed without a read");

    property p_flag_sticky;
        !st.powerOnFlag |=> !st.powerOnFlag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("reset flag set again without a reset");

    property p_addr_opens;
        cmd.addrValid && !cmd.stop
            |=> st.pointer == $past(cmd.data) && st.phase == PH_ADDRESSED;
    endproperty
    a_addr_opens: assert property (p_addr_opens)
        else $error("start address did not open a transfer");

    property p_stop_closes;
        cmd.stop |=> st.phase == PH_IDLE;
    endproperty
    a_stop_closes: assert property (p_stop_closes)
        else $error("stop did not close the transfer");

    // ********************************************************************
    // Cover points
    // ********************************************************************
    c_burst_write: cover property (writeTaken ##1 writeTaken ##1 writeTaken);
    c_rom_load: cover property (loadNow);
    c_status_read: cover property (readValid && readData[POR_BIT]);
    c_read_after_write: cover property (writeTaken ##[1:20] readValid);
    c_addressed_read: cover property (cmd.addrValid ##[1:4] readValid);
endmodule : tuner_control_register_bank

// ### tuner_control_register_bank_bench.sv
`timescale 1ns/1ps
module tuner_control_register_bank_bench
    import tuner_regs_pkg::*;
;
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic srst = 1'b1;
    link_cmd_t cmd;
    logic [2:0] lockIndicator = 3'h0;
    tuner_ctrl_t ctrl;
    logic [7:0] readData;
    logic readValid;
    int failures = 0;
    int totalChecks = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_5CF3;
    logic [10:0][7:0] shadow;
    always #5 clk = ~clk;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [7:0] romByte(input int i);
        return 8'(i * 29 + 60);
    endfunction : romByte
    function automatic logic [ROM_ENTRIES*8-1:0] romImage();
        logic [ROM_ENTRIES*8-1:0] r;
        for (int i = 0; i < ROM_ENTRIES; i++) r[i*8+:8] = romByte(i);
        return r;
    endfunction : romImage
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic tuner_ctrl_t expCtrl(input logic [10:0][7:0] b);
        return {b[0][6:0], b[1], b[2][6:0], b[3],
            b[4][6:0], b[5][3:0], b[6][7:3],
            b[7], b[8][5:0], b[9][3:0]};
    endfunction : expCtrl
    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        totalChecks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_tuner_host_model.pulse(4'h8, a);
        shadow[a] = u_tuner_host_model.legal(a, d);
        u_tuner_host_model.pulse(4'h4, shadow[a]);
        u_tuner_host_model.pulse(4'h1, 8'h00);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        logic [7:0] d;
        logic ok;
        u_tuner_host_model.pulse(4'h8, a);
        u_tuner_host_model.getByte(d, ok);
        check("read valid", 64'(1), 64'(ok));
        check(name, 64'(exp), 64'(d));
        u_tuner_host_model.pulse(4'h1, 8'h00);
    endtask : rd
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            print_verdict();
        end
    end
    tuner_control_register_bank #(.ROM_SIZE(ROM_ENTRIES), .ROM_CONTENT(romImage()))
    u_tuner_control_register_bank (.clk(clk), .srst(srst), .cmd(cmd),
        .lockIndicator(lockIndicator), .ctrl(ctrl), .readData(readData), .readValid(readValid));
    tuner_host_model u_tuner_host_model (.clk(clk), .cmd(cmd), .readData(readData),
        .readValid(readValid));
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [3:0] e;
        logic ok;
        int n;
        shadow = {8'h00, 8'h00, 8'h09, 8'h0F, 8'h00, 8'h01, 8'h00, 8'hBE, 8'h10, 8'h50, 8'h12};
        lockIndicator = 3'(rnd());
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check("reset ctrl", expCtrl(shadow), ctrl);
        rd(8'h0C, {1'b1, lockIndicator, 4'h0}, "status first");
        rd(8'h0C, {1'b0, lockIndicator, 4'h0}, "status again");
        $display("Test reset done");
        // Every code of the two-bit selector fields, the factory-only ones filtered by the host
        for (int k = 0; k < 4; k++) begin
            wr(8'h03, 8'(k * 8'h49));
            wr(8'h04, 8'(k * 5));
            wr(8'h05, 8'(k * 5));
            wr(8'h06, 8'(k * 8'h48));
            check("code ctrl", expCtrl(shadow), ctrl);
        end
        for (int t = 0; t < 30; t++) begin
            a = 8'(rnd() % 10); // Start stays below 0x0a
            n = 1 + int'(rnd() % (10 - a));
            u_tuner_host_model.pulse(4'h8, a);
            for (int i = 0; i < n; i++) begin
                shadow[a + i] = u_tuner_host_model.legal(8'(a + i), 8'(rnd()));
                if (t[0]) begin
                    u_tuner_host_model.pulse(4'h4, shadow[a + i]);
                end
            end
            // Even rounds send the data back to back, one byte each cycle
            if (!t[0]) begin
                u_tuner_host_model.stream(shadow, int'(a), n);
            end
            u_tuner_host_model.pulse(4'h1, 8'h00);
            check("burst ctrl", expCtrl(shadow), ctrl);
        end
        u_tuner_host_model.pulse(4'h8, 8'h00);
        for (int i = 0; i < 11; i++) begin
            u_tuner_host_model.getByte(d, ok);
            check("burst read", 64'(shadow[i]), 64'(d));
        end
        // Point at a live register first so that a stray store would show
        u_tuner_host_model.pulse(4'h8, 8'h07);
        u_tuner_host_model.pulse(4'h1, 8'h00);
        u_tuner_host_model.pulse(4'h4, ~shadow[7]);
        check("closed write", expCtrl(shadow), ctrl);
        $display("Test bursts done");
        for (int k = 0; k < 4; k++) begin
            e = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'(rnd());
            wr(8'h09, {4'h0, e});
            wr(8'h08, shadow[8] & 8'h7F);
            wr(8'h08, shadow[8] | 8'h80);
            rd(8'h0B, romByte(e), "rom readback");
            wr(8'h09, {4'h0, ~e});
            wr(8'h08, shadow[8] | 8'h80);
            rd(8'h0B, romByte(e), "rom no reload");
        end
        u_tuner_host_model.pulse(4'h8, 8'h0B);
        u_tuner_host_model.pulse(4'h4, ~romByte(e));
        u_tuner_host_model.pulse(4'h1, 8'h00);
        rd(8'h0B, romByte(e), "rom read only");
        check("rom ctrl", expCtrl(shadow), ctrl);
        $display("Test rom load done");
        // A reset in mid-run must bring back the defaults and the flag
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        check("divider after reset", 64'(15'h1250), 64'(ctrl.intDivider));
        rd(8'h0C, {1'b1, lockIndicator, 4'h0}, "status after reset");
        $display("Test mid reset done");
        print_verdict();
    end
endmodule : tuner_control_register_bank_bench

// ### tuner_host_model.sv
`timescale 1ns/1ps
module tuner_host_model
    import tuner_regs_pkg::*;
(
    input wire logic clk, // Bank clock
    output link_cmd_t cmd, // Byte events toward the bank
    input wire logic [7:0] readData, // Byte answered by the bank
    input wire logic readValid // Marks that byte
);
    // ****************************************************************
    // Host side of the byte link
    // ****************************************************************
    initial cmd = '0;
    // Host keeps reserved bits at zero and never sends factory-only codes
    function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        case (a)
            8'h00: v[7] = 1'b0;
            8'h02: v = {1'b0, (d[6:0] < 7'h10) ? 7'h10 : d[6:0]};
            8'h04: v = {1'b0, d[6:2], (d[1:0] == 2'b11) ? 2'b10 : d[1:0]};
            8'h05: v = {4'h0, d[3:2], (d[1:0] == 2'b11) ? 2'b10 : d[1:0]};
            8'h06: v = {d[7] ? 2'b11 : 2'b00, d[5:3], 3'h0};
            8'h08: v[6] = 1'b0;
            8'h09: v[7:4] = 4'h0;
            default: v = d;
        endcase
        return v;
    endfunction : legal
    // Data is inverted once released so a stale byte is never mistaken for a live one
    task automatic pulse(input logic [3:0] kind, input logic [7:0] d);
        @(negedge clk);
        cmd <= {kind, d};
        @(negedge clk);
        cmd <= {4'h0, ~d};
    endtask : pulse
    // Back-to-back data bytes, one each cycle, to run the pointer at full rate
    task automatic stream(input logic [10:0][7:0] b, input int first, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            cmd <= {4'h4, b[first + i]};
        end
        @(negedge clk);
        cmd <= {4'h0, ~b[first + n - 1]};
    endtask : stream
    task automatic getByte(output logic [7:0] d, output logic ok);
        @(negedge clk);
        cmd <= {4'h2, 8'h00};
        @(negedge clk);
        ok = readValid;
        d = readData;
        cmd <= {4'h0, 8'hFF};
    endtask : getByte
endmodule : tuner_host_model

// ### tuner_regs_pkg.sv
package tuner_regs_pkg;
    // ********************************************************************
    // Register addresses
    // ********************************************************************
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h00;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h01;
    localparam logic [7:0] ADDR_REF_DIV = 8'h02;
    localparam logic [7:0] ADDR_OSC = 8'h03;
    localparam logic [7:0] ADDR_DET_PUMP = 8'h04;
    localparam logic [7:0] ADDR_INPUT = 8'h05;
    localparam logic [7:0] ADDR_POWER = 8'h06;
    localparam logic [7:0] ADDR_SERIES = 8'h07;
    localparam logic [7:0] ADDR_PARALLEL = 8'h08;
    localparam logic [7:0] ADDR_ROM_PTR = 8'h09;
    localparam logic [7:0] ADDR_RESERVED = 8'h0A;
    localparam logic [7:0] ADDR_ROM_DATA = 8'h0B;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    localparam int BANK_REGS = 11;
    localparam int ROM_ENTRIES = 16;
    // ********************************************************************
    // Field positions
    // ********************************************************************
    localparam int LOAD_BIT = 7;
    localparam int POR_BIT = 7;
    // ********************************************************************
    // Reset values, index 10 first
    // ********************************************************************
    localparam logic [BANK_REGS-1:0][7:0] BANK_RESET = {
        8'h00, 8'h00, 8'h09, 8'h0F, 8'h00, 8'h01,
        8'h00, 8'hBE, 8'h10, 8'h50, 8'h12};
    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {
        PH_IDLE = 2'b01,
        PH_ADDRESSED = 2'b10
    } phase_t;
    typedef struct packed {
        logic addrValid;
        logic writeValid;
        logic readReq;
        logic stop;
        logic [7:0] data;
    } link_cmd_t;
    typedef struct packed {
        logic [14:0] intDivider;
        logic [6:0] refDivider;
        logic [1:0] oscillatorSelect;
        logic [2:0] subBandSelect;
        logic lockDetectEnable;
        logic [1:0] outputDividerRatio;
        logic [2:0] overloadDetectorSetting;
        logic [1:0] pumpCurrentSelect;
        logic [1:0] filterBandSelect;
        logic rfPowerOff;
        logic ifAmpPowerOff;
        logic [1:0] rfInputSelect;
        logic [1:0] mixerPowerOff;
        logic ifSectionPowerOff;
        logic detectorPowerOff;
        logic synthesizerPowerOff;
        logic [7:0] seriesCapCode;
        logic [5:0] parallelCapCode;
        logic [3:0] romEntryPointer;
    } tuner_ctrl_t;
    typedef struct packed {
        phase_t phase;
        logic [7:0] pointer;
        logic [BANK_REGS-1:0][7:0] bank;
        logic [7:0] romReadbackValue;
        logic powerOnFlag;
        logic [2:0] lockSync1;
        logic [2:0] lockSync2;
        logic [7:0] readData;
        logic readValid;
    } bank_state_t;
endpackage : tuner_regs_pkg
